/* timer_pkg.sv */
/*
 Constants for the timer run-control block: register byte addresses,
 field positions, reset values and prescaler last counts.
 Assumes a 32-bit byte address bus and 16-bit read data.
*/
package timer_pkg;
   localparam int ADDR_W   = 32;
   localparam int DATA_W   = 16;
   localparam int CNT_W    = 16;
   localparam int NUM_CH   = 7;
   localparam int NUM_MODE = 2;
   localparam int PRE_W    = 5;

   // Channel order: timer0, timer1, timer9 .. timer13.
   localparam logic [ADDR_W-1:0] RUN_OFFSET [NUM_CH] = '{
      32'hFFFF_F140, 32'hFFFF_F150, 32'hFFFF_F1D0, 32'hFFFF_F1E0,
      32'hFFFF_F1F0, 32'hFFFF_F200, 32'hFFFF_F210};
   localparam logic [ADDR_W-1:0] COUNT_OFFSET [NUM_CH] = '{
      32'hFFFF_F300, 32'hFFFF_F302, 32'hFFFF_F304, 32'hFFFF_F306,
      32'hFFFF_F308, 32'hFFFF_F30A, 32'hFFFF_F30C};
   localparam logic [ADDR_W-1:0] MODE_OFFSET [NUM_MODE] = '{
      32'hFFFF_F142, 32'hFFFF_F152};
   localparam logic [ADDR_W-1:0] CAP_FIRST_OFFSET [NUM_MODE] = '{
      32'hFFFF_F320, 32'hFFFF_F324};
   localparam logic [ADDR_W-1:0] CAP_SECOND_OFFSET [NUM_MODE] = '{
      32'hFFFF_F322, 32'hFFFF_F326};

   // Run register fields.
   localparam int RUN_DBUF_BIT = 7;
   localparam int RUN_IDLE_BIT = 3;
   localparam int RUN_PRUN_BIT = 2;
   localparam int RUN_CRUN_BIT = 0;
   localparam logic [7:0] RUN_RESET = 8'h00;
   localparam logic [7:0] RUN_MASK  = 8'hDD;

   // Mode register fields.
   localparam int MODE_SWCAP_BIT = 5;
   localparam int MODE_CPM_LSB   = 3;
   localparam int MODE_CLK_LSB   = 0;
   localparam logic [7:0] MODE_RESET = 8'h20;
   localparam logic [7:0] MODE_MASK  = 8'hDF;
   localparam logic [1:0] CPM_PEER_FALL = 2'h3;
   localparam logic [1:0] CLK_SEL_DEFAULT = 2'h1;

   // Prescaler last counts (divisor minus one) for clock selects 1, 2 and 3; select 0 acts as 1.
   localparam logic [PRE_W-1:0] PRE_LAST_SEL1 = 5'h01;
   localparam logic [PRE_W-1:0] PRE_LAST_SEL2 = 5'h07;
   localparam logic [PRE_W-1:0] PRE_LAST_SEL3 = 5'h1F;
endpackage

/* timer_prescaler.sv */
/*
 Per-channel prescaler: emits one-cycle ticks at the selected division.
 Assumes run, select and clock enable come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
   import timer_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_reset_n,
   input  wire logic       i_clk_en,
   input  wire logic       i_run,
   input  wire logic [1:0] i_select,
   output logic            o_tick
);
   typedef struct packed {
      logic [PRE_W-1:0] div;
      logic             tick;
   } pre_state_s;

   pre_state_s       state;
   pre_state_s       next_state;
   logic [PRE_W-1:0] last;

   always_comb begin
      case (i_select)
         2'h2:    last = PRE_LAST_SEL2;
         2'h3:    last = PRE_LAST_SEL3;
         default: last = PRE_LAST_SEL1;
      endcase
      next_state = state;
      next_state.tick = 1'b0;
      // Stopping resets the divider so the next start gives a full period.
      if (!i_run) begin
         next_state.div = '0;
      end else if (state.div >= last) begin
         next_state.div = '0;
         next_state.tick = 1'b1;
      end else begin
         next_state.div = state.div + 5'h01;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= '0;
      end else if (i_clk_en) begin
         state <= next_state;
      end
   end

   assign o_tick = state.tick;
endmodule
`default_nettype wire

/* timer_upcounter.sv */
/*
 Per-channel 16-bit up-counter with synchronous clear.
 Assumes tick, enable and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_upcounter
   import timer_pkg::*;
(
   input  wire logic             i_mclk,
   input  wire logic             i_reset_n,
   input  wire logic             i_clk_en,
   input  wire logic             i_tick,
   input  wire logic             i_count_en,
   input  wire logic             i_clear,
   output logic      [CNT_W-1:0] o_count
);
   typedef struct packed {
      logic [CNT_W-1:0] count;
   } cnt_state_s;

   cnt_state_s state;
   cnt_state_s next_state;

   always_comb begin
      next_state = state;
      if (i_clear) begin
         next_state.count = '0;
      end else if (i_count_en && i_tick) begin
         next_state.count = state.count + 16'h0001;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= '0;
      end else if (i_clk_en) begin
         state <= next_state;
      end
   end

   assign o_count = state.count;
endmodule
`default_nettype wire

/* timer16_run_control.sv */
/*
 Run control for a bank of 16-bit timer channels (timer0, timer1,
 timer9 .. timer13), with software and peer-edge capture on timer0/1.
 Assumes a plain register port on i_mclk, an idle-mode flag from the
 power controller on the same clock, and a peer timer output that may
 be asynchronous.
*/
// Added by the designer: the address-and-strobe port.
// What this block does
// - Run bit 7 enables double buffering; resets to 0.
// - Run bit 0 lets the counter count; 0 stops and clears it.
// - Run bit 3 set keeps the channel running in idle; 0 halts.
// - Run bit 2 starts the prescaler; 0 stops it; resets to 0.
// - Run bits 1 and 5 are not stored and read back 0.
// - Writing 0 to software-capture bit latches counter into first capture.
// - In peer capture mode, peer output falling edge latches second capture.
`timescale 1ns/1ps
`default_nettype none
module timer16_run_control
   import timer_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_reset_n,
   input  wire logic              i_clk_en,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wr_data,
   input  wire logic              i_wr_en,
   input  wire logic              i_rd_en,
   input  wire logic              i_idle_mode,
   input  wire logic              i_peer_timer_output,
   output logic      [DATA_W-1:0] o_rd_data,
   output logic      [NUM_CH-1:0] o_double_buffer_enable,
   output logic      [NUM_CH-1:0] o_counter_running
);

   typedef struct packed {
      logic [NUM_CH-1:0][7:0]         run;
      logic [NUM_MODE-1:0][7:0]       mode;
      logic [NUM_MODE-1:0][CNT_W-1:0] cap_first;
      logic [NUM_MODE-1:0][CNT_W-1:0] cap_second;
      logic                           peer_meta;
      logic                           peer_sync;
      logic                           peer_prev;
      logic [NUM_CH-1:0]              running;
      logic [DATA_W-1:0]              rd_data;
   } ctrl_state_s;

   ctrl_state_s                state;
   ctrl_state_s                next_state;
   logic [NUM_CH-1:0][CNT_W-1:0] count;
   logic [NUM_CH-1:0]          tick;
   logic [NUM_CH-1:0]          awake;
   logic [NUM_CH-1:0]          pre_run;
   logic [NUM_CH-1:0]          cnt_en;
   logic [NUM_CH-1:0]          cnt_clear;
   logic [NUM_CH-1:0][1:0]     clk_sel;
   logic                       peer_fall;

   // Channel datapaths: one prescaler and one counter each.
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
         assign awake[ch] = !i_idle_mode || state.run[ch][RUN_IDLE_BIT];
         assign pre_run[ch] = state.run[ch][RUN_PRUN_BIT] && awake[ch];
         assign cnt_en[ch] = pre_run[ch] && state.run[ch][RUN_CRUN_BIT];
         assign cnt_clear[ch] = !state.run[ch][RUN_CRUN_BIT];

         if (ch < NUM_MODE) begin : g_sel
            assign clk_sel[ch] = state.mode[ch][MODE_CLK_LSB +: 2];
         end else begin : g_fixed
            assign clk_sel[ch] = CLK_SEL_DEFAULT;
         end

         timer_prescaler u_pre (
            .i_mclk    (i_mclk),
            .i_reset_n (i_reset_n),
            .i_clk_en  (i_clk_en),
            .i_run     (pre_run[ch]),
            .i_select  (clk_sel[ch]),
            .o_tick    (tick[ch])
         );

         timer_upcounter u_cnt (
            .i_mclk     (i_mclk),
            .i_reset_n  (i_reset_n),
            .i_clk_en   (i_clk_en),
            .i_tick     (tick[ch]),
            .i_count_en (cnt_en[ch]),
            .i_clear    (cnt_clear[ch]),
            .o_count    (count[ch])
         );
      end
   endgenerate

   // The peer edge is taken only from the second synchroniser stage.
   assign peer_fall = state.peer_prev && !state.peer_sync;

   always_comb begin
      next_state = state;
      next_state.rd_data = '0;

      // Synchroniser for the peer timer output, then edge history.
      next_state.peer_meta = i_peer_timer_output;
      next_state.peer_sync = state.peer_meta;
      next_state.peer_prev = state.peer_sync;

      next_state.running = cnt_en;

      // Register writes.
      if (i_wr_en) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (i_addr == RUN_OFFSET[i]) begin
               // bits 6 and 4 stored as written
               next_state.run[i] = i_wr_data[7:0] & RUN_MASK;
            end
         end
         for (int m = 0; m < NUM_MODE; m++) begin
            if (i_addr == MODE_OFFSET[m]) begin
               // The capture bit is a command, so it always reads back 1.
               next_state.mode[m] = (i_wr_data[7:0] & MODE_MASK) | MODE_RESET;
               if (!i_wr_data[MODE_SWCAP_BIT]) begin
                  next_state.cap_first[m] = count[m];
               end
            end
         end
      end

      for (int m = 0; m < NUM_MODE; m++) begin
         if (peer_fall &&
             (state.mode[m][MODE_CPM_LSB +: 2] == CPM_PEER_FALL)) begin
            next_state.cap_second[m] = count[m];
         end
      end

      // Register reads: data appear for one cycle after the strobe.
      if (i_rd_en) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (i_addr == RUN_OFFSET[i]) begin
               next_state.rd_data = {8'h00, state.run[i] & RUN_MASK};
            end
            if (i_addr == COUNT_OFFSET[i]) begin
               next_state.rd_data = count[i];
            end
         end
         for (int m = 0; m < NUM_MODE; m++) begin
            if (i_addr == MODE_OFFSET[m]) begin
               next_state.rd_data = {8'h00, state.mode[m]};
            end
            if (i_addr == CAP_FIRST_OFFSET[m]) begin
               next_state.rd_data = state.cap_first[m];
            end
            if (i_addr == CAP_SECOND_OFFSET[m]) begin
               next_state.rd_data = state.cap_second[m];
            end
         end
      end
   end

   // Clock enable freezes every register, including read data.
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= '{run:        {NUM_CH{RUN_RESET}},
                    mode:       {NUM_MODE{MODE_RESET}},
                    cap_first:  '0,
                    cap_second: '0,
                    peer_meta:  1'b1,
                    peer_sync:  1'b1,
                    peer_prev:  1'b1,
                    running:    '0,
                    rd_data:    '0};
      end else if (i_clk_en) begin
         state <= next_state;
      end
   end

   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_out
         assign o_double_buffer_enable[ch] = state.run[ch][RUN_DBUF_BIT];
      end
   endgenerate

   assign o_rd_data         = state.rd_data;
   assign o_counter_running = state.running;
endmodule
`default_nettype wire

/* timer_run_asserts.sv */
/*
 Checker for timer16_run_control, bound to its ports.
 Assumes timer0 run bits change only through the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_run_asserts
   import timer_pkg::*;
(
   input wire logic              i_mclk,
   input wire logic              i_reset_n,
   input wire logic              i_clk_en,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wr_data,
   input wire logic              i_wr_en,
   input wire logic              i_rd_en,
   input wire logic              i_idle_mode,
   input wire logic              i_peer_timer_output,
   input wire logic [DATA_W-1:0] o_rd_data,
   input wire logic [NUM_CH-1:0] o_double_buffer_enable,
   input wire logic [NUM_CH-1:0] o_counter_running
);
   logic [7:0] run0;
   logic       wr_ok;
   logic       rd_ok;
   logic       run_ok;
   assign wr_ok  = i_wr_en && i_clk_en;
   assign rd_ok  = i_rd_en && i_clk_en;
   assign run_ok = run0[2] && run0[0] && (run0[3] || !i_idle_mode);
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         run0 <= RUN_RESET;
      end else if (wr_ok && i_addr == RUN_OFFSET[0]) begin
         run0 <= i_wr_data[7:0];
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   a_dbuf_follow: assert property (
      wr_ok && i_addr == RUN_OFFSET[0] |=> o_double_buffer_enable[0] == $past(i_wr_data[7]))
      else $error("double buffer enable missed a write");
   a_dbuf_hold: assert property (!wr_ok |=> $stable(o_double_buffer_enable))
      else $error("double buffer enable changed without a write");
   a_run_follow: assert property (
      $past(i_clk_en) |-> o_counter_running[0] == $past(run_ok))
      else $error("counter running flag wrong");
   a_prun_off: assert property (!run0[2] [*2] |-> !o_counter_running[0])
      else $error("counter runs with prescaler stopped");
   a_idle_halt: assert property (
      (i_idle_mode && !run0[3]) [*2] |-> !o_counter_running[0])
      else $error("counter runs in idle");
   a_stop_clear: assert property (
      (!run0[0]) [*2] ##0 (rd_ok && i_addr == COUNT_OFFSET[0]) |=> o_rd_data == 16'h0000)
      else $error("stopped counter not cleared");
   a_rd_mask: assert property (
      rd_ok && i_addr == RUN_OFFSET[0] |=> (o_rd_data & 16'h008D) == {8'h00, $past(run0) & 8'h8D})
      else $error("run register readback wrong");
   a_run9_stop: assert property (
      wr_ok && i_addr == RUN_OFFSET[2] && !i_wr_data[0] |-> ##2 !o_counter_running[2])
      else $error("timer9 kept running after stop");
   c_idle: cover property ((i_idle_mode && !run0[3] && run0[0]) [*2]);
   c_swcap: cover property (wr_ok && i_addr == MODE_OFFSET[0] && !i_wr_data[5]);
   c_peer: cover property ($fell(i_peer_timer_output));
endmodule
bind timer16_run_control timer_run_asserts u_chk (.i_mclk, .i_reset_n, .i_clk_en, .i_addr,
   .i_wr_data, .i_wr_en, .i_rd_en, .i_idle_mode, .i_peer_timer_output, .o_rd_data,
   .o_double_buffer_enable, .o_counter_running);
`default_nettype wire

/* tb.sv */
/*
 Self-checking bench for timer16_run_control.
 Assumes the package register map and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import timer_pkg::*;
   logic              i_mclk = 1'b0;
   logic              i_reset_n = 1'b0;
   logic              i_clk_en = 1'b1;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wr_data = '0;
   logic              i_wr_en = 1'b0;
   logic              i_rd_en = 1'b0;
   logic              i_idle_mode = 1'b0;
   logic              i_peer_timer_output = 1'b1;
   logic [DATA_W-1:0] o_rd_data;
   logic [NUM_CH-1:0] o_double_buffer_enable;
   logic [NUM_CH-1:0] o_counter_running;
   logic [DATA_W-1:0] d;
   logic [DATA_W-1:0] c;
   int                n_fail = 0;
   int                n_tests = 0;
   localparam logic [7:0] ROWS [5] = '{8'h80, 8'h08, 8'h8D, 8'h84, 8'h01};
   localparam logic       ROW_DB [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
   timer16_run_control dut (.i_mclk, .i_reset_n, .i_clk_en, .i_addr, .i_wr_data, .i_wr_en,
      .i_rd_en, .i_idle_mode, .i_peer_timer_output, .o_rd_data, .o_double_buffer_enable,
      .o_counter_running);
   initial begin
      forever #5 i_mclk = ~i_mclk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] v);
      i_addr    <= a;
      i_wr_data <= v;
      i_wr_en   <= 1'b1;
      @(posedge i_mclk);
      i_wr_en <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic rd(input logic [31:0] a, output logic [15:0] v);
      i_addr  <= a;
      i_rd_en <= 1'b1;
      @(posedge i_mclk);
      i_rd_en <= 1'b0;
      #1 v = o_rd_data;
      @(posedge i_mclk);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #50000;
      n_fail++;
      end_of_test();
   end
   // Readback is masked: bits 1 and 5 are undefined, bits 6 and 4 are always written 0.
   initial begin
      tick(4);
      i_reset_n <= 1'b1;
      tick(1);
      for (int k = 0; k < NUM_CH; k++) begin
         rd(RUN_OFFSET[k], d);
         chk(d & 16'h00DD, {8'h00, RUN_RESET});
      end
      for (int r = 0; r < 5; r++) begin
         for (int k = 0; k < NUM_CH; k++) begin
            wr(RUN_OFFSET[k], {8'h00, ROWS[r]});
            rd(RUN_OFFSET[k], d);
            chk(d & 16'h00DD, {8'h00, ROWS[r]});
            chk({15'h0000, o_double_buffer_enable[k]}, {15'h0000, ROW_DB[r]});
         end
      end
      tick(40);
      rd(COUNT_OFFSET[0], d);
      chk(d, 16'h0000);
      chk({9'h000, o_counter_running}, 16'h0000);
      wr(RUN_OFFSET[0], 16'h0005);
      tick(20);
      chk({15'h0000, o_counter_running[0]}, 16'h0001);
      wr(RUN_OFFSET[0], 16'h0001);
      rd(COUNT_OFFSET[0], c);
      chk({15'h0000, c == 16'h0000}, 16'h0000);
      tick(10);
      rd(COUNT_OFFSET[0], d);
      chk(d, c);
      wr(MODE_OFFSET[0], 16'h0001);
      rd(CAP_FIRST_OFFSET[0], d);
      chk(d, c);
      wr(MODE_OFFSET[0], 16'h0039);
      i_peer_timer_output <= 1'b1;
      tick(6);
      rd(CAP_SECOND_OFFSET[0], d);
      chk(d, 16'h0000);
      i_peer_timer_output <= 1'b0;
      tick(6);
      rd(CAP_SECOND_OFFSET[0], d);
      chk(d, c);
      wr(RUN_OFFSET[0], 16'h0005);
      i_idle_mode <= 1'b1;
      tick(4);
      rd(COUNT_OFFSET[0], c);
      tick(10);
      rd(COUNT_OFFSET[0], d);
      chk(d, c);
      wr(RUN_OFFSET[0], 16'h000D);
      tick(10);
      rd(COUNT_OFFSET[0], d);
      chk({15'h0000, d == c}, 16'h0000);
      wr(MODE_OFFSET[0], 16'h0039);
      rd(CAP_FIRST_OFFSET[0], d);
      chk(d, c);
      rd(COUNT_OFFSET[0], c);
      i_clk_en <= 1'b0;
      tick(12);
      i_clk_en <= 1'b1;
      rd(COUNT_OFFSET[0], d);
      chk({15'h0000, (d - c) < 16'h0002}, 16'h0001);
      i_idle_mode <= 1'b0;
      wr(RUN_OFFSET[0], 16'h000C);
      rd(COUNT_OFFSET[0], d);
      chk(d, 16'h0000);
      rd(32'hFFFF_F1D2, d);
      chk(d, 16'h0000);
      wr(RUN_OFFSET[0], 16'h0085);
      i_reset_n <= 1'b0;
      tick(2);
      i_reset_n <= 1'b1;
      tick(1);
      chk({9'h000, o_double_buffer_enable}, 16'h0000);
      rd(RUN_OFFSET[0], d);
      chk(d & 16'h00DD, 16'h0000);
      end_of_test();
   end
endmodule
`default_nettype wire
